/* ptv_window_decode.sv */
// PCI target window decode and translation with its AHB-Lite register file.
//
// Function
// - Base register holds the lowest PCI address the window claims.
// - Claim only addresses at or above base and strictly below bound.
// - Bound of zero means no upper limit above base.
// - Windows zero and four compare base and bound on bits 31 to 12.
// - Other windows compare base and bound at 64 KByte granularity.
// - Upper outgoing address bits are PCI bits plus offset bits.
// - Block select counts only for A24/A32 with width 8, 16 or 32.
// - A24/A32 with 64-bit width permits multiplexed block transfers.
// - I/O space windows ignore posted writes; all transfers coupled.
// - Width field 00/01/10/11 is 8/16/32/64 bits, reset to 10.
// - Space field: A16, A24, A32, reserved x2, CR/CSR, user1, user2.
// - Window disabled claims nothing; enabled decodes normally.
// - Program/data attribute: 0 gives data, 1 gives program.
// - Block select 0 gives single cycles, 1 gives block transfers.
// - Space select 0 answers memory space, 1 answers I/O space.
//
// Decided for this implementation: the AHB-Lite register port.
`timescale 1ns/1ps
module ptv_window_decode
  import ptv_pkg::*;
#(
  parameter int WINDOW_ID = 4
) (
  input wire logic hclk, // Bus clock, 100 MHz.
  input wire logic hresetn, // Asynchronous reset, active low.
  input wire logic hsel, // Slave select.
  input wire logic [31:0] haddr, // Byte address.
  input wire logic [1:0] htrans, // Transfer type.
  input wire logic hwrite, // Write when high.
  input wire logic [2:0] hsize, // Transfer size.
  input wire logic [31:0] hwdata, // Write data.
  input wire logic hready, // Bus ready in.
  output logic hreadyout, // Slave ready, always high.
  output logic hresp, // Response, always OKAY.
  output logic [31:0] hrdata, // Read data.
  input wire ptv_req_t pci_req, // Incoming PCI address to decode.
  output ptv_res_t vme_res // Registered decode result.
);

  localparam logic [31:0] GMASK = ptv_gran_mask(WINDOW_ID);

  // Registers live in the lowest 4 KByte page; higher pages alias nothing.
  function automatic logic reg_page(input logic [31:0] a);
    return a[31:12] == 20'h00000;
  endfunction : reg_page

  // Only A24 and A32 spaces carry block transfers of either kind.
  function automatic logic blk_capable(input ptv_space_t s);
    return s == PTV_AS_A24 || s == PTV_AS_A32;
  endfunction : blk_capable

  logic [31:0] win_base;
  logic [31:0] win_bound;
  logic [31:0] win_xlat;
  logic [31:0] win_ctrl;
  logic wr_pend;
  logic [11:0] wr_ofs;
  logic [31:0] next_rdata;
  logic addr_ok;

  // A read issued straight after a write to the same register sees the old
  // word, because read data is fetched in the overlapping address phase.
  // Only aligned whole words are stored; other accesses read zero.
  assign addr_ok = hsel && hready && htrans == PTV_HTRANS_NONSEQ &&
                   hsize == 3'h2 && haddr[1:0] == 2'h0;

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // A write is remembered in its address phase and lands at the end of the
  // data phase, the only cycle in which hwdata stands.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      wr_ofs <= 12'h000;
    end else begin
      wr_pend <= addr_ok && hwrite && reg_page(haddr);
      wr_ofs <= haddr[11:0];
    end
  end

  always_comb begin
    next_rdata = 32'h0000_0000;
    if (reg_page(haddr)) begin
      unique case (haddr[11:0])
        PTV_OFS_BASE: next_rdata = win_base;
        PTV_OFS_BOUND: next_rdata = win_bound;
        PTV_OFS_XLAT: next_rdata = win_xlat;
        PTV_OFS_CTRL: next_rdata = win_ctrl;
        default: next_rdata = 32'h0000_0000;
      endcase
    end
  end

  // Read data is fetched in the address phase so the data phase needs no wait.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (addr_ok && !hwrite) begin
      hrdata <= next_rdata;
    end else begin
      hrdata <= 32'h0000_0000;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      win_base <= PTV_ADDR_RST;
      win_bound <= PTV_ADDR_RST;
      win_xlat <= PTV_ADDR_RST;
      win_ctrl <= PTV_CTRL_RST;
    end else if (wr_pend) begin
      unique case (wr_ofs)
        PTV_OFS_BASE: win_base <= hwdata & GMASK;
        PTV_OFS_BOUND: win_bound <= hwdata & GMASK;
        PTV_OFS_XLAT: win_xlat <= hwdata & GMASK;
        PTV_OFS_CTRL: win_ctrl <= hwdata & PTV_CTRL_MASK;
        default: win_ctrl <= win_ctrl;
      endcase
    end
  end

  // Control field views. This window's own control word qualifies its
  // decode; reserved bits are never stored, so they read zero.
  logic c_en;
  logic c_post;
  logic c_io_space;
  logic c_block;
  ptv_width_t c_width;
  ptv_space_t c_space;
  assign c_en = win_ctrl[PTV_EN_BIT];
  assign c_post = win_ctrl[PTV_POST_BIT];
  assign c_io_space = win_ctrl[PTV_IOSPACE_BIT];
  assign c_block = win_ctrl[PTV_BLOCK_BIT];
  assign c_width = ptv_width_t'(win_ctrl[PTV_WIDTH_LSB +: 2]);
  assign c_space = ptv_space_t'(win_ctrl[PTV_SPACE_LSB +: 3]);

  logic blk_space;
  logic in_range;
  logic claim;
  logic [31:0] req_hi;
  logic [31:0] next_vaddr;

  assign blk_space = blk_capable(c_space);
  assign req_hi = pci_req.addr & GMASK;
  // Lower bound inclusive, upper bound exclusive, zero bound is open ended.
  assign in_range = req_hi >= win_base &&
                    (win_bound == 32'h0000_0000 ||
                     req_hi < win_bound);
  assign claim = pci_req.valid && c_en &&
                 pci_req.io == c_io_space && in_range;
  // Carry out of bit 31 is dropped: the sum wraps like the two's complement
  // addition the hardware performs.
  assign next_vaddr = ((req_hi + win_xlat) & GMASK) |
                      (pci_req.addr & ~GMASK);

  // Attributes mirror the control word on every edge so the cycle engine sees
  // them early; only the flags that start a transfer wait for a claim.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      vme_res <= '0;
    end else begin
      vme_res.valid <= pci_req.valid;
      vme_res.hit <= claim;
      vme_res.vme_addr <= claim ? next_vaddr : 32'h0000_0000;
      vme_res.posted <= claim && c_post && !c_io_space;
      vme_res.width <= c_width;
      vme_res.space <= c_space;
      vme_res.space_rsvd <= c_space == PTV_AS_RSV3 ||
                            c_space == PTV_AS_RSV4;
      vme_res.prog_attr <= win_ctrl[PTV_PROG_BIT];
      vme_res.supervisor <= win_ctrl[PTV_SUPER_BIT];
      vme_res.block <= claim && c_block && blk_space &&
                       c_width != PTV_DW64;
      vme_res.mblt_ok <= claim && blk_space && c_width == PTV_DW64;
    end
  end

  // Every check below runs on the bus clock and sleeps while reset is held.
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  a_hit_needs_enable: assert property (
    vme_res.hit |-> $past(win_ctrl[PTV_EN_BIT]))
    else $error("hit while window disabled");

  a_hit_above_base: assert property (
    vme_res.hit |-> ($past(pci_req.addr) & GMASK) >= $past(win_base))
    else $error("hit below base");

  a_hit_below_bound: assert property (
    (vme_res.hit && $past(win_bound) != 32'h0000_0000) |->
      ($past(pci_req.addr) & GMASK) < $past(win_bound))
    else $error("hit at or above bound");

  a_open_bound_hit: assert property (
    (pci_req.valid && c_en && pci_req.io == c_io_space &&
     win_bound == 32'h0000_0000 && (pci_req.addr & GMASK) >= win_base)
      |=> vme_res.hit)
    else $error("open-ended window missed address");

  a_space_match: assert property (
    vme_res.hit |-> $past(pci_req.io) == $past(win_ctrl[PTV_IOSPACE_BIT]))
    else $error("hit in wrong PCI space");

  a_xlat_sum: assert property (
    vme_res.hit |-> vme_res.vme_addr[31:12] ==
      20'($past(pci_req.addr[31:12]) + $past(win_xlat[31:12])))
    else $error("translated address wrong");

  a_low_passthru: assert property (
    vme_res.hit |-> vme_res.vme_addr[11:0] == $past(pci_req.addr[11:0]))
    else $error("low address bits altered");

  a_io_coupled: assert property (
    $past(win_ctrl[PTV_IOSPACE_BIT]) |-> !vme_res.posted)
    else $error("posted write through I/O window");

  a_block_gate: assert property (
    vme_res.block |-> vme_res.width != PTV_DW64 &&
      (vme_res.space == PTV_AS_A24 || vme_res.space == PTV_AS_A32))
    else $error("block transfer outside allowed space or width");

  a_mblt_gate: assert property (
    vme_res.mblt_ok |-> vme_res.width == PTV_DW64 && !vme_res.block)
    else $error("multiplexed block flag wrong");

  a_ctrl_reset: assert property (
    $rose(hresetn) |-> win_ctrl[PTV_WIDTH_LSB +: 2] == 2'h2)
    else $error("width field reset value wrong");

  // Where the checks below hold the registered result against the inputs or the
  // control word, they use the values one edge earlier, when the decode looked at them.

  a_hit_needs_valid: assert property (
    vme_res.hit |-> vme_res.valid)
    else $error("hit without a request");

  a_idle_no_hit: assert property (
    !$past(pci_req.valid) |-> !vme_res.hit)
    else $error("hit from an idle request line");

  a_miss_quiet: assert property (
    !vme_res.hit |-> vme_res.vme_addr == 32'h0000_0000 &&
      !vme_res.posted && !vme_res.block && !vme_res.mblt_ok)
    else $error("transfer flags raised without a hit");

  a_base_miss: assert property (
    (pci_req.valid && (pci_req.addr & GMASK) < win_base)
      |=> !vme_res.hit)
    else $error("address below base was claimed");

  a_bound_miss: assert property (
    (pci_req.valid && win_bound != 32'h0000_0000 &&
     (pci_req.addr & GMASK) >= win_bound) |=> !vme_res.hit)
    else $error("address at or above bound was claimed");

  a_wrong_space: assert property (
    (pci_req.valid && pci_req.io != c_io_space) |=> !vme_res.hit)
    else $error("access of the other PCI space was claimed");

  a_gran_mask: assert property (
    ((win_base | win_bound | win_xlat) & ~GMASK) == 32'h0000_0000)
    else $error("address register holds bits below granularity");

  a_width_mirror: assert property (
    vme_res.valid |-> vme_res.width == $past(c_width))
    else $error("width attribute does not follow control");

  a_space_mirror: assert property (
    vme_res.valid |-> vme_res.space == $past(c_space))
    else $error("space attribute does not follow control");

  a_space_rsvd: assert property (
    vme_res.space_rsvd == (vme_res.space == PTV_AS_RSV3 ||
                           vme_res.space == PTV_AS_RSV4))
    else $error("reserved space flag wrong");

  a_prog_attr: assert property (
    vme_res.valid |-> vme_res.prog_attr == $past(win_ctrl[PTV_PROG_BIT]))
    else $error("program attribute does not follow control");

  a_super_attr: assert property (
    vme_res.valid |->
      vme_res.supervisor == $past(win_ctrl[PTV_SUPER_BIT]))
    else $error("supervisor attribute does not follow control");

  a_block_select: assert property (
    (vme_res.hit && blk_capable(vme_res.space) &&
     vme_res.width != PTV_DW64) |-> vme_res.block == $past(c_block))
    else $error("block select not honoured");

  a_mblt_any_select: assert property (
    (vme_res.hit && blk_capable(vme_res.space) &&
     vme_res.width == PTV_DW64) |-> vme_res.mblt_ok)
    else $error("multiplexed block not offered at 64-bit width");

  a_posted_mem: assert property (
    (vme_res.hit && !$past(c_io_space)) |-> vme_res.posted == $past(c_post))
    else $error("posted write enable not honoured");

endmodule : ptv_window_decode

/* ptv_pkg.sv */
// Shared constants, field layout and carrier types of the target window decode.
package ptv_pkg;

  // Register byte offsets.
  localparam logic [11:0] PTV_OFS_BASE = 12'h1a4;
  localparam logic [11:0] PTV_OFS_BOUND = 12'h1a8;
  localparam logic [11:0] PTV_OFS_XLAT = 12'h1ac;
  localparam logic [11:0] PTV_OFS_CTRL = 12'h1b4;

  // Reset values.
  localparam logic [31:0] PTV_ADDR_RST = 32'h0000_0000;
  localparam logic [31:0] PTV_CTRL_RST = 32'h0080_0000;

  // Control field positions.
  localparam int PTV_EN_BIT = 31;
  localparam int PTV_POST_BIT = 30;
  localparam int PTV_WIDTH_LSB = 22;
  localparam int PTV_SPACE_LSB = 16;
  localparam int PTV_PROG_BIT = 14;
  localparam int PTV_SUPER_BIT = 12;
  localparam int PTV_BLOCK_BIT = 8;
  localparam int PTV_IOSPACE_BIT = 0;
  localparam logic [31:0] PTV_CTRL_MASK = 32'hc0c7_5101;

  // Granularity in address bits for fine and coarse windows.
  localparam int PTV_GRAN_FINE = 12;
  localparam int PTV_GRAN_COARSE = 16;

  localparam logic [1:0] PTV_HTRANS_NONSEQ = 2'h2;

  typedef enum logic [1:0] {
    PTV_DW8 = 2'h0,
    PTV_DW16 = 2'h1,
    PTV_DW32 = 2'h2,
    PTV_DW64 = 2'h3
  } ptv_width_t;

  typedef enum logic [2:0] {
    PTV_AS_A16 = 3'h0,
    PTV_AS_A24 = 3'h1,
    PTV_AS_A32 = 3'h2,
    PTV_AS_RSV3 = 3'h3,
    PTV_AS_RSV4 = 3'h4,
    PTV_AS_CRCSR = 3'h5,
    PTV_AS_USER1 = 3'h6,
    PTV_AS_USER2 = 3'h7
  } ptv_space_t;

  typedef struct packed {
    logic valid;
    logic io;
    logic [31:0] addr;
  } ptv_req_t;

  typedef struct packed {
    logic valid;
    logic hit;
    logic [31:0] vme_addr;
    logic posted;
    ptv_width_t width;
    ptv_space_t space;
    logic space_rsvd;
    logic prog_attr;
    logic supervisor;
    logic block;
    logic mblt_ok;
  } ptv_res_t;

  // Mask of the compared address bits for a given window number.
  function automatic logic [31:0] ptv_gran_mask(input int win);
    int g;
    g = (win == 0 || win == 4) ? PTV_GRAN_FINE : PTV_GRAN_COARSE;
    return 32'hffff_ffff << g;
  endfunction : ptv_gran_mask

endpackage : ptv_pkg

/* ptv_pci_model.sv */
// PCI-side requester that feeds addresses to the window decode.
`timescale 1ns/1ps
module ptv_pci_model
  import ptv_pkg::*;
(
  input wire logic hclk, // Bus clock.
  output ptv_req_t pci_req, // Address offered for decode.
  input wire ptv_res_t vme_res // Decode result, one cycle later.
);
  initial pci_req = '0;

  // Offers one address for one cycle and returns the result seen next cycle.
  task automatic issue(input logic io, input logic [31:0] a,
                       output ptv_res_t r);
    @(posedge hclk);
    pci_req <= {1'b1, io, a};
    @(posedge hclk);
    // Released lines show the inverse so a stale value never looks valid.
    pci_req <= {1'b0, ~io, ~a};
    @(posedge hclk);
    r = vme_res;
  endtask : issue
endmodule : ptv_pci_model

/* tb_top.sv */
// Self-checking bench for the target window decode and its registers.
`timescale 1ns/1ps
module tb_top
  import ptv_pkg::*;
;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  wire logic hready;
  ptv_req_t pci_req;
  ptv_res_t vme_res;
  int bad_count, comparisons, cycles;

  assign hready = hreadyout;

  ptv_window_decode #(.WINDOW_ID(4)) dut_u (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .pci_req(pci_req), .vme_res(vme_res));

  ptv_pci_model pm_u (.hclk(hclk), .pci_req(pci_req), .vme_res(vme_res));

  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : close_out

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic bus(input logic wr, input logic [11:0] ofs,
                     input logic [31:0] wd, output logic [31:0] rd);
    hsel <= 1'b1;
    haddr <= {20'h0, ofs};
    hwrite <= wr;
    hsize <= 3'h2;
    htrans <= PTV_HTRANS_NONSEQ;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
    chk({31'h0, hresp}, 32'h0000_0000);
  endtask : bus

  task automatic wr(input logic [11:0] ofs, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, ofs, d, x);
  endtask : wr

  task automatic rd_chk(input logic [11:0] ofs, input logic [31:0] e);
    logic [31:0] x;
    bus(1'b0, ofs, 32'h0, x);
    chk(x, e);
  endtask : rd_chk

  // Expected attribute vector for control word c when the window hits or not.
  function automatic logic [11:0] exp_attr(input logic h, input logic [31:0] c);
    logic e;
    e = (c[18:16] == 3'h1) || (c[18:16] == 3'h2);
    return {h, h & c[30] & ~c[0], c[23:22], c[18:16],
            c[18:16] == 3'h3 || c[18:16] == 3'h4, c[14], c[12],
            h & c[8] & e & (c[23:22] != 2'h3), h & e & (c[23:22] == 2'h3)};
  endfunction : exp_attr

  task automatic probe(input logic io, input logic [31:0] a, input logic h,
                       input logic [31:0] va, input logic [31:0] c);
    ptv_res_t r;
    pm_u.issue(io, a, r);
    chk(r.vme_addr, va);
    chk(32'({r.valid, r.hit, r.posted, r.width, r.space, r.space_rsvd,
        r.prog_attr, r.supervisor, r.block, r.mblt_ok}),
        32'({1'b1, exp_attr(h, c)}));
  endtask : probe

  task automatic t_regs();
    rd_chk(PTV_OFS_BASE, 32'h0);
    rd_chk(PTV_OFS_BOUND, 32'h0);
    rd_chk(PTV_OFS_XLAT, 32'h0);
    rd_chk(PTV_OFS_CTRL, 32'h0080_0000);
    wr(PTV_OFS_BASE, 32'hffff_ffff);
    rd_chk(PTV_OFS_BASE, 32'hffff_f000);
    wr(PTV_OFS_CTRL, 32'hffff_ffff);
    rd_chk(PTV_OFS_CTRL, 32'hc0c7_5101);
    wr(12'h1b0, 32'hffff_ffff);
    rd_chk(12'h1b0, 32'h0);
    $display("t_regs done");
  endtask : t_regs

  task automatic t_range();
    logic [31:0] a[5] = '{32'h0fff_ffff, 32'h1000_0000, 32'h1000_2abc,
                          32'h1000_2fff, 32'h1000_3000};
    logic [4:0] h = 5'b01110;
    wr(PTV_OFS_BASE, 32'h1000_0000);
    wr(PTV_OFS_BOUND, 32'h1000_3000);
    wr(PTV_OFS_XLAT, 32'h0000_1000);
    wr(PTV_OFS_CTRL, 32'h8082_0000);
    for (int i = 0; i < 5; i++)
      probe(1'b0, a[i], h[4-i], h[4-i] ? a[i] + 32'h1000 : 32'h0,
            32'h8082_0000);
    wr(PTV_OFS_XLAT, 32'hf000_0000);
    wr(PTV_OFS_BOUND, 32'h0);
    probe(1'b0, 32'hffff_f123, 1'b1, 32'hefff_f123, 32'h8082_0000);
    wr(PTV_OFS_CTRL, 32'h0082_0000);
    probe(1'b0, 32'h1000_0123, 1'b0, 32'h0, 32'h0082_0000);
    wr(PTV_OFS_CTRL, 32'hc082_0000);
    probe(1'b1, 32'h1000_0123, 1'b0, 32'h0, 32'hc082_0000);
    probe(1'b0, 32'h1000_0123, 1'b1, 32'h0000_0123, 32'hc082_0000);
    wr(PTV_OFS_CTRL, 32'hc082_0001);
    probe(1'b1, 32'h1000_0456, 1'b1, 32'h0000_0456, 32'hc082_0001);
    $display("t_range done");
  endtask : t_range

  task automatic t_attrs();
    logic [31:0] c;
    for (int w = 0; w < 4; w++)
      for (int s = 0; s < 8; s++) begin
        c = 32'h8000_0000 | (32'(w) << 22) | (32'(s) << 16);
        c = c | (s[0] ? 32'h4000 : 32'h0) | (w[1] ? 32'h1000 : 32'h0);
        c = c | ((w[0] ^ s[0]) ? 32'h0100 : 32'h0);
        wr(PTV_OFS_CTRL, c);
        probe(1'b0, 32'h2000_0010, 1'b1, 32'h1000_0010, c);
      end
    $display("t_attrs done");
  endtask : t_attrs

  initial begin
    bad_count = 0;
    comparisons = 0;
    cycles = 0;
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    htrans = 2'h0;
    hwdata = 32'h0;
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    // The whole run needs well under this many cycles.
    fork
      begin
        t_regs();
        t_range();
        t_attrs();
      end
      begin
        while (cycles < 5000) begin
          @(posedge hclk);
          cycles++;
        end
        chk(32'(cycles), 32'h0000_0000);
      end
    join_any
    close_out();
  end
endmodule : tb_top
